// File: hdl/dapt_pkg.sv
package dapt_pkg;
  localparam int NumBanks = 4;
  localparam int BankWidth = 2;
  localparam int CntWidth = 8;
  localparam int ClkPeriodPs = 5000;
  // Analog times in picoseconds.
  localparam int TrasPs = 40000;
  localparam int TrtpPs = 7500;
  localparam int TrpPs = 15000;
  localparam int TwrPs = 15000;
  localparam int TrcPs = 55000;
  // Cycle counts, rounded up.
  localparam int TrasCyc = (TrasPs + ClkPeriodPs - 1) / ClkPeriodPs;
  localparam int RtpCyc = (TrtpPs + ClkPeriodPs - 1) / ClkPeriodPs;
  localparam int TrpCyc = (TrpPs + ClkPeriodPs - 1) / ClkPeriodPs;
  localparam int TwrCyc = (TwrPs + ClkPeriodPs - 1) / ClkPeriodPs;
  localparam int TrcCyc = (TrcPs + ClkPeriodPs - 1) / ClkPeriodPs;
  localparam int AddLat = 0;
  localparam int CasLat = 4;
  localparam int WrLat = AddLat + CasLat - 1;
  localparam int PrefetchGap = 2;
  localparam int PchSpacing = 1;
  typedef enum logic [2:0] {CmdNop, CmdAct, CmdRd, CmdWr, CmdPre} dapt_cmd_t;
endpackage

// File: hdl/dapt_if.sv
`timescale 1ns/1ps
interface dapt_if;
  import dapt_pkg::*;
  dapt_cmd_t cmd;
  logic [1:0] bank;
  logic autoCloseFlag;
  logic burstLen8;
  logic [NumBanks-1:0] bankOpen;
  logic [NumBanks-1:0] prechargeStart;
  modport ctrl (output cmd, bank, autoCloseFlag, burstLen8, input bankOpen, prechargeStart);
  modport mem (input cmd, bank, autoCloseFlag, burstLen8, output bankOpen, prechargeStart);
endinterface

// File: hdl/dapt_down_counter.sv
`timescale 1ns/1ps
module dapt_down_counter
  import dapt_pkg::*;
#(
  parameter int Width = CntWidth
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [Width-1:0] value,
  output logic done
);
  logic [Width-1:0] count;
  assign done = (count == '0);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count <= '0;
    else if (load)
      count <= value;
    else if (!done)
      count <= count - 1'b1;
  end
endmodule // dapt_down_counter

// File: hdl/dapt_memory_end.sv
`timescale 1ns/1ps
// What the two ends of the link do
// - Controller closes bank before another row.
// - A10 on read/write selects auto-close.
// - Read auto-close starts AL+BL/2 later.
// - Read auto-close waits for tRAS.
// - Read auto-close waits for tRTP.
// - tRP timed from actual precharge start.
// - Read auto-close to activate spacing.
// - Controller rounds tRTP and tRP up.
// - Precharge two clocks after last prefetch.
// - Reactivate after tRP and tRC.
// - Write auto-close after data plus tWR.
// - Write reactivate after WR+tRP and tRC.
// - Lockout holds auto-close until tRAS.
// - Read to precharge spacing rule.
// - Write to precharge spacing rule.
// - One cycle between precharges.
// - RTP is tRTP over tCK, rounded up.
module dapt_memory_end
  import dapt_pkg::*;
#(
  parameter int Banks = NumBanks
)
(
  input wire logic clk,
  input wire logic rst_n,
  dapt_if.mem link,
  output logic [Banks-1:0] pendingClose
);
  initial
  begin
    if (Banks != NumBanks)
      $error("Bank count must match the bank address width.");
  end
  // Hold loads are one short, as the count loads at the end of the command cycle and the start pulse shows while it reads zero.
  localparam logic [CntWidth-1:0] RdNominal = CntWidth'(AddLat + 2 - 1);
  localparam logic [CntWidth-1:0] RdNominal8 = CntWidth'(AddLat + 4 - 1);
  localparam logic [CntWidth-1:0] RtpLoad = CntWidth'(AddLat + RtpCyc - 1);
  localparam logic [CntWidth-1:0] RtpLoad8 = CntWidth'(AddLat + 2 + RtpCyc - 1);
  localparam logic [CntWidth-1:0] PfLoad = CntWidth'(AddLat + PrefetchGap - 1);
  localparam logic [CntWidth-1:0] PfLoad8 = CntWidth'(AddLat + 2 + PrefetchGap - 1);
  localparam logic [CntWidth-1:0] WrLoad = CntWidth'(WrLat + 2 + TwrCyc - 1);
  localparam logic [CntWidth-1:0] WrLoad8 = CntWidth'(WrLat + 4 + TwrCyc - 1);
  localparam logic [CntWidth-1:0] TrasLoad = CntWidth'(TrasCyc - 1);
  logic [Banks-1:0] bankOpen;
  logic [Banks-1:0] startNow;
  genvar b;
  generate
    for (b = 0; b < Banks; b++)
    begin : g_bank
      wire hit = (link.bank == BankWidth'(b));
      wire isAct = hit && (link.cmd == CmdAct);
      wire isRd = hit && (link.cmd == CmdRd);
      wire isWr = hit && (link.cmd == CmdWr);
      wire isPre = (link.cmd == CmdPre) && (hit || link.autoCloseFlag);
      wire armClose = (isRd || isWr) && link.autoCloseFlag;
      logic [CntWidth-1:0] holdValue;
      logic rasDone, holdDone;
      always_comb
      begin
        holdValue = '0;
        if (isRd)
        begin
          // The largest of nominal edge, tRTP and prefetch gap wins.
          holdValue = link.burstLen8 ? RdNominal8 : RdNominal;
          if ((link.burstLen8 ? RtpLoad8 : RtpLoad) > holdValue)
            holdValue = link.burstLen8 ? RtpLoad8 : RtpLoad;
          if ((link.burstLen8 ? PfLoad8 : PfLoad) > holdValue)
            holdValue = link.burstLen8 ? PfLoad8 : PfLoad;
        end
        else if (isWr)
          holdValue = link.burstLen8 ? WrLoad8 : WrLoad;
      end
      dapt_down_counter u_ras (
        .clk(clk),
        .rst_n(rst_n),
        .load(isAct),
        .value(TrasLoad),
        .done(rasDone)
      );
      dapt_down_counter u_hold (
        .clk(clk),
        .rst_n(rst_n),
        .load(isRd || isWr),
        .value(holdValue),
        .done(holdDone)
      );
      // The precharge begins on the cycle every timer has expired.
      assign startNow[b] = pendingClose[b] && rasDone && holdDone && !(isRd || isWr);
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          bankOpen[b] <= 1'b0;
          pendingClose[b] <= 1'b0;
        end
        else
        begin
          if (isAct)
            bankOpen[b] <= 1'b1;
          else if (isPre || startNow[b])
            bankOpen[b] <= 1'b0;
          if (armClose)
            pendingClose[b] <= 1'b1;
          else if (startNow[b] || isPre)
            pendingClose[b] <= 1'b0;
        end
      end
    end
  endgenerate
  assign link.bankOpen = bankOpen;
  assign link.prechargeStart = startNow;
endmodule // dapt_memory_end

// File: hdl/dapt_ctrl_end.sv
`timescale 1ns/1ps
module dapt_ctrl_end
  import dapt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dapt_cmd_t reqCmd,
  input wire logic [1:0] reqBank,
  input wire logic reqAutoClose,
  input wire logic reqBurst8,
  output logic reqReady,
  dapt_if.ctrl link
);
  localparam logic [CntWidth-1:0] RdPre4 = CntWidth'(AddLat + 2 + ((RtpCyc > 2) ? RtpCyc : 2) - 2);
  localparam logic [CntWidth-1:0] RdPre8 = CntWidth'(AddLat + 4 + ((RtpCyc > 2) ? RtpCyc : 2) - 2);
  localparam logic [CntWidth-1:0] WrPre4 = CntWidth'(WrLat + 2 + TwrCyc);
  localparam logic [CntWidth-1:0] WrPre8 = CntWidth'(WrLat + 4 + TwrCyc);
  localparam logic [CntWidth-1:0] RdAp4 = CntWidth'(AddLat + RtpCyc + TrpCyc - 1);
  localparam logic [CntWidth-1:0] RdAp8 = CntWidth'(AddLat + 2 + RtpCyc + TrpCyc - 1);
  localparam logic [CntWidth-1:0] WrAp4 = CntWidth'(WrLat + 2 + TwrCyc + TrpCyc - 1);
  localparam logic [CntWidth-1:0] WrAp8 = CntWidth'(WrLat + 4 + TwrCyc + TrpCyc - 1);
  localparam logic [CntWidth-1:0] RasLoad = CntWidth'(TrasCyc - 1);
  localparam logic [CntWidth-1:0] RcLoad = CntWidth'(TrcCyc - 1);
  localparam logic [CntWidth-1:0] RpLoad = CntWidth'(TrpCyc - 1);
  logic [NumBanks-1:0] okAct, okPre, isOpen;
  logic prevPre;
  genvar b;
  generate
    for (b = 0; b < NumBanks; b++)
    begin : g_bank
      wire hit = (reqBank == BankWidth'(b));
      wire go = reqReady && (reqCmd != CmdNop);
      wire act = go && hit && (reqCmd == CmdAct);
      wire rd = go && hit && (reqCmd == CmdRd);
      wire wr = go && hit && (reqCmd == CmdWr);
      wire pre = go && (reqCmd == CmdPre) && (hit || reqAutoClose);
      logic rasOk, rcOk, preOk, actOk;
      logic [CntWidth-1:0] preVal, actVal;
      always_comb
      begin
        preVal = reqBurst8 ? RdPre8 : RdPre4;
        actVal = reqBurst8 ? RdAp8 : RdAp4;
        if (wr)
        begin
          preVal = reqBurst8 ? WrPre8 : WrPre4;
          actVal = reqBurst8 ? WrAp8 : WrAp4;
        end
        else if (pre)
          actVal = RpLoad;
      end
      dapt_down_counter u_ras (.clk(clk), .rst_n(rst_n), .load(act), .value(RasLoad), .done(rasOk));
      dapt_down_counter u_rc (.clk(clk), .rst_n(rst_n), .load(act), .value(RcLoad), .done(rcOk));
      dapt_down_counter u_pre (.clk(clk), .rst_n(rst_n), .load(rd || wr), .value(preVal),
        .done(preOk));
      dapt_down_counter u_act (.clk(clk), .rst_n(rst_n),
        .load(pre || ((rd || wr) && reqAutoClose)), .value(actVal), .done(actOk));
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          isOpen[b] <= 1'b0;
        else if (act)
          isOpen[b] <= 1'b1;
        else if (pre || ((rd || wr) && reqAutoClose))
          isOpen[b] <= 1'b0;
      end
      assign okAct[b] = !isOpen[b] && rcOk && actOk;
      assign okPre[b] = rasOk && preOk && actOk;
    end
  endgenerate
  wire preAll = reqAutoClose;
  wire preLegal = (preAll ? &okPre : okPre[reqBank]) && !prevPre;
  always_comb
  begin
    unique case (reqCmd)
      CmdAct: reqReady = okAct[reqBank];
      CmdRd, CmdWr: reqReady = isOpen[reqBank];
      CmdPre: reqReady = preLegal;
      default: reqReady = 1'b1;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      link.cmd <= CmdNop;
      link.bank <= 2'h0;
      link.autoCloseFlag <= 1'b0;
      link.burstLen8 <= 1'b0;
      prevPre <= 1'b0;
    end
    else
    begin
      link.cmd <= reqReady ? reqCmd : CmdNop;
      link.bank <= reqBank;
      link.autoCloseFlag <= reqAutoClose;
      link.burstLen8 <= reqBurst8;
      prevPre <= reqReady && (reqCmd == CmdPre);
    end
  end
endmodule // dapt_ctrl_end

// File: test/dapt_link_asserts.sv
`timescale 1ns/1ps
module dapt_link_asserts
  import dapt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dapt_cmd_t cmd,
  input wire logic [1:0] bank,
  input wire logic autoCloseFlag,
  input wire logic burstLen8,
  input wire logic [NumBanks-1:0] bankOpen,
  input wire logic [NumBanks-1:0] prechargeStart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sAct0;
    cmd == CmdAct && bank == 2'h0;
  endsequence
  sequence sRdClose0;
    cmd == CmdRd && autoCloseFlag && bank == 2'h0 && !burstLen8;
  endsequence
  sequence sWrClose0;
    cmd == CmdWr && autoCloseFlag && bank == 2'h0 && !burstLen8;
  endsequence
  a_act_opens_bank: assert property (sAct0 |=> bankOpen[0])
    else $error("activate did not open bank 0");
  a_ras_holds_close: assert property (sAct0 |=> !prechargeStart[0] [*7])
    else $error("bank 0 closed before row-active minimum");
  a_rd_not_early: assert property (sRdClose0 |=> !prechargeStart[0])
    else $error("read close started too early");
  a_rd_close_bound: assert property (sRdClose0 |-> ##[2:8] prechargeStart[0])
    else $error("read close did not start in time");
  a_wr_close_exact: assert property (sWrClose0 |=> !prechargeStart[0] [*7] ##1 prechargeStart[0])
    else $error("write close not after data plus recovery");
  a_close_pulse: assert property (prechargeStart[0] |=> !prechargeStart[0])
    else $error("close start longer than one cycle");
  a_close_ends_open: assert property (prechargeStart[0] |=> !bankOpen[0])
    else $error("bank 0 still open after close");
  a_pre_spacing: assert property (cmd == CmdPre |=> cmd != CmdPre)
    else $error("precharge commands back to back");
  a_act_after_rp: assert property (prechargeStart[0] |=> !(cmd == CmdAct && bank == 2'h0) [*2])
    else $error("bank 0 activated inside precharge time");
endmodule // dapt_link_asserts

// File: test/ddr2_auto_precharge_timing_bench.sv
`timescale 1ns/1ps
module ddr2_auto_precharge_timing_bench;
  import dapt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dapt_cmd_t reqCmd = CmdNop;
  logic [1:0] reqBank = 2'h0;
  logic reqAutoClose = 1'b0;
  logic reqBurst8 = 1'b0;
  logic reqReady;
  logic [NumBanks-1:0] pendingClose;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int actAt [4];
  int cmdAt [4];
  int closeAt [4];
  dapt_if linkBus ();
  dapt_ctrl_end dapt_ctrl_end_inst (.clk(clk), .rst_n(rst_n), .reqCmd(reqCmd), .reqBank(reqBank),
    .reqAutoClose(reqAutoClose), .reqBurst8(reqBurst8), .reqReady(reqReady), .link(linkBus.ctrl));
  dapt_memory_end dapt_memory_end_inst (.clk(clk), .rst_n(rst_n), .link(linkBus.mem),
    .pendingClose(pendingClose));
  dapt_link_asserts dapt_link_asserts_inst (.clk(clk), .rst_n(rst_n), .cmd(linkBus.cmd),
    .bank(linkBus.bank), .autoCloseFlag(linkBus.autoCloseFlag), .burstLen8(linkBus.burstLen8),
    .bankOpen(linkBus.bankOpen), .prechargeStart(linkBus.prechargeStart));
  initial forever #2.5 clk = ~clk;
  // Cycle stamps of commands and close starts seen on the link.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (linkBus.cmd == CmdAct) actAt[linkBus.bank] <= cyc;
    if (linkBus.cmd == CmdRd || linkBus.cmd == CmdWr) cmdAt[linkBus.bank] <= cyc;
    for (int b = 0; b < 4; b++) if (linkBus.prechargeStart[b]) closeAt[b] <= cyc;
    if (cyc == 3000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until the edge at which ready is seen high.
  task automatic issue(input dapt_cmd_t c, input logic [1:0] b, input logic ac, input logic b8);
    logic r;
    @(negedge clk);
    reqCmd = c;
    reqBank = b;
    reqAutoClose = ac;
    reqBurst8 = b8;
    for (int n = 0; n < 100; n++)
    begin
      #2;
      r = reqReady;
      @(posedge clk);
      if (r === 1'b1) break;
    end
    @(negedge clk);
    reqCmd = CmdNop;
  endtask
  task automatic wait_idle(input logic [1:0] b);
    for (int n = 0; n < 40 && linkBus.bankOpen[b] !== 1'b0; n++) @(negedge clk);
  endtask
  task automatic ras_hold_test();
    issue(CmdAct, 2'h0, 1'b0, 1'b0);
    issue(CmdRd, 2'h0, 1'b1, 1'b0);
    @(negedge clk);
    check(8'(pendingClose[0]), 8'h01);
    wait_idle(2'h0);
    check(8'(closeAt[0] - actAt[0]), 8'(TrasCyc));
  endtask
  task automatic read_close_test(input logic [1:0] b, input logic b8, input int exp);
    issue(CmdAct, b, 1'b0, 1'b0);
    repeat (TrasCyc + 2) @(negedge clk);
    issue(CmdRd, b, 1'b1, b8);
    wait_idle(b);
    check(8'(closeAt[b] - cmdAt[b]), 8'(exp));
  endtask
  task automatic write_close_test(input logic b8, input int exp);
    issue(CmdAct, 2'h0, 1'b0, 1'b0);
    repeat (TrasCyc + 2) @(negedge clk);
    issue(CmdWr, 2'h0, 1'b1, b8);
    wait_idle(2'h0);
    check(8'(closeAt[0] - cmdAt[0]), 8'(exp));
  endtask
  task automatic reopen_test();
    int prevAct;
    prevAct = actAt[0];
    issue(CmdAct, 2'h0, 1'b0, 1'b0);
    @(negedge clk);
    check(8'(actAt[0] - closeAt[0] >= TrpCyc), 8'h01);
    check(8'(actAt[0] - prevAct >= TrcCyc), 8'h01);
    issue(CmdRd, 2'h0, 1'b0, 1'b0);
    repeat (TrasCyc + 4) @(negedge clk);
    check(8'({linkBus.bankOpen[0], pendingClose[0]}), 8'h02);
    issue(CmdPre, 2'h0, 1'b0, 1'b0);
    issue(CmdPre, 2'h0, 1'b1, 1'b0);
    repeat (4) @(negedge clk);
    check(8'(linkBus.bankOpen), 8'h00);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    ras_hold_test();
    read_close_test(2'h1, 1'b0, AddLat + 2);
    read_close_test(2'h2, 1'b1, AddLat + 2 + RtpCyc);
    write_close_test(1'b0, WrLat + 2 + TwrCyc);
    write_close_test(1'b1, WrLat + 4 + TwrCyc);
    reopen_test();
    stop_test();
  end
endmodule // ddr2_auto_precharge_timing_bench
